// file: verif/hpg_link_asserts.sv
`timescale 1ns/1ps
module hpg_link_asserts (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic cfg_diff,
	input wire hpg_pkg::hpg_rx_mode_e cfg_rx_mode,
	input wire hpg_pkg::hpg_tx_mode_e cfg_tx_mode,
	input wire logic tx_oe,
	input wire logic second_leg_drive_enable,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic bypass_pad_tap,
	input wire logic delay_adjust_enable,
	input wire logic delay_step_direction,
	input wire logic delay_counter_clear,
	input wire logic delay_step_done,
	input wire logic [hpg_pkg::TAP_W-1:0] delay_tap
);
	import hpg_pkg::*;
	// Single clock domain, reset masks every check
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	// Modes that hand over words only at register clock edges, rising or falling, not every cycle
	wire logic rx_slow;
	assign rx_slow = cfg_rx_mode inside {RX_REG, RX_DDR, RX_DDR_RESYNC, RX_DESER};
	chk_tap_top_hold: assert property (
		delay_tap == TAP_MAX && !delay_counter_clear |=> delay_tap != TAP_MIN)
		else $error("delay tap wrapped upward");
	chk_tap_bottom_hold: assert property (
		delay_tap == TAP_MIN |=> delay_tap != TAP_MAX)
		else $error("delay tap wrapped downward");
	// single step in the asked direction
	chk_tap_one_step: assert property (
		$changed(delay_tap) && !$past(delay_counter_clear) |-> $past(delay_adjust_enable)
		&& delay_tap == ($past(delay_step_direction) ? $past(delay_tap) + TAP_ONE
		: $past(delay_tap) - TAP_ONE))
		else $error("delay tap moved wrongly");
	chk_tap_clear_init: assert property (
		$changed(delay_tap) && $past(delay_counter_clear) |-> delay_tap == TAP_INIT)
		else $error("clear left tap elsewhere");
	chk_step_done_seen: assert property (
		$changed(delay_tap) |-> ##[0:1] delay_step_done)
		else $error("tap moved without done");
	// register clock is every fourth cycle
	chk_ready_gap: assert property (
		tx_ready && cfg_tx_mode != TX_PLAIN |=> !tx_ready || cfg_tx_mode == TX_PLAIN)
		else $error("launch ready twice in a row");
	chk_ready_period: assert property (
		$rose(tx_ready) && cfg_tx_mode != TX_PLAIN |-> ##4 (tx_ready || cfg_tx_mode == TX_PLAIN))
		else $error("launch ready period wrong");
	// plain capture hands over every cycle
	chk_rx_plain_flow: assert property (
		$past(RST_N) && $past(cfg_rx_mode) == RX_PLAIN && cfg_rx_mode == RX_PLAIN |-> rx_valid)
		else $error("plain capture missed a cycle");
	// registered modes pulse once per edge
	chk_rx_pulse_once: assert property (
		rx_slow && $past(rx_slow) && rx_valid |=> !rx_valid)
		else $error("capture valid stretched");
	chk_bypass_off: assert property (
		rx_slow |=> !bypass_pad_tap)
		else $error("bypass active with register");
	chk_second_leg_eq: assert property (
		cfg_diff |-> second_leg_drive_enable == tx_oe)
		else $error("second leg enable differs");
endmodule : hpg_link_asserts

// file: verif/hs_pin_pair_gpio_port_tb_top.sv
`timescale 1ns/1ps
module hs_pin_pair_gpio_port_tb_top;
	import hpg_pkg::*;
	logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic ext_p, ext_n, p_o, p_oe, n_o, n_oe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] taken[$];
	int error_cnt, cmp_count;
	hpg_rx_mode_e rm[4] = '{RX_REG, RX_DDR, RX_DDR_RESYNC, RX_DESER};
	logic [3:0] rmask[4] = '{4'h1, 4'h3, 4'h3, 4'hF};
	// Pad pattern per capture mode and the word the rules predict for it
	logic [3:0] rpat[4] = '{4'h1, 4'h4, 4'h4, 4'hE};
	logic [3:0] rexp[4] = '{4'h1, 4'h2, 4'h2, 4'hE};
	hpg_tx_mode_e tm[3] = '{TX_SER, TX_DDR, TX_REG};
	logic [3:0] tw[3] = '{4'h6, 4'h6, 4'h1};
	logic [3:0] tseq[3] = '{4'h6, 4'hC, 4'hF};
	// Pads show the driving party, else the board level
	wire logic pad_p;
	wire logic pad_n;
	assign pad_p = p_oe ? p_o : ext_p;
	assign pad_n = n_oe ? n_o : ext_n;
	hpg_link_if link();
	hpg_pin_pair u_hpg_pin_pair (.CLK_SYS(clk_sys), .RST_N(rst_n), .LINK(link),
		.PAD_P_I(pad_p), .PAD_P_O(p_o), .PAD_P_OE(p_oe),
		.PAD_N_I(pad_n), .PAD_N_O(n_o), .PAD_N_OE(n_oe));
	hpg_fabric_ctl u_hpg_fabric_ctl (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .LINK(link));
	hpg_link_asserts u_hpg_link_asserts (.CLK_SYS(clk_sys), .RST_N(rst_n),
		.cfg_diff(link.cfg_diff), .cfg_rx_mode(link.cfg_rx_mode),
		.cfg_tx_mode(link.cfg_tx_mode), .tx_oe(link.tx_oe),
		.second_leg_drive_enable(link.second_leg_drive_enable), .tx_ready(link.tx_ready),
		.rx_valid(link.rx_valid), .bypass_pad_tap(link.bypass_pad_tap),
		.delay_adjust_enable(link.delay_adjust_enable),
		.delay_step_direction(link.delay_step_direction),
		.delay_counter_clear(link.delay_counter_clear),
		.delay_step_done(link.delay_step_done), .delay_tap(link.delay_tap));
	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Words launched in registered mode, in take order
	always @(posedge clk_sys) begin
		if (rst_n && link.tx_valid && link.tx_ready && link.cfg_tx_mode == TX_REG) begin
			taken.push_back(link.tx_word);
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// One transfer; an idle edge first so a release never meets the next setup
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] ctl(input logic [2:0] rx, input logic [1:0] tx,
		input logic drv, input logic oer, input logic diff);
		return {24'h0, drv, oer, tx, rx, diff};
	endfunction : ctl
	// Delay command, then poll until the step has landed
	task automatic dly(input logic [31:0] cmd);
		int n = 0;
		apb(1'b1, REG_DELAY, cmd);
		do begin
			apb(1'b0, REG_DELAY, 32'h0);
			n++;
		end while (rd[DLY_BUSY_BIT] !== 1'b0 && n < 20);
	endtask : dly
	// Drive a pattern phase-locked to the register edge, then wait a word
	task automatic rx_run(input logic [3:0] p);
		int n = 0;
		do @(posedge clk_sys); while (link.tx_ready !== 1'b1 && ++n < 8);
		for (int k = 1; k < 17; k++) begin
			ext_p <= p[k % 4];
			@(posedge clk_sys);
		end
		do @(posedge clk_sys); while (link.rx_valid !== 1'b1 && ++n < 16);
	endtask : rx_run
	// Push a word, find its take edge, then compare four pad cycles
	task automatic tx_run(input logic [3:0] w, input logic [3:0] s);
		int n = 0;
		apb(1'b1, REG_TXDATA, {28'h0, w});
		do @(posedge clk_sys); while (!(link.tx_valid && link.tx_ready) && ++n < 16);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			check({30'h0, p_oe, p_o}, {30'h0, 1'b1, s[i]});
		end
	endtask : tx_run
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	// Whole run is about a thousand cycles; this cuts a hang short
	initial begin
		repeat (30000) @(posedge clk_sys);
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		finish_test();
	end
	initial begin
		{rst_n, psel, penable, pwrite, ext_p, ext_n} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		// reset state, refused address leaves control alone
		apb(1'b0, REG_DELAY, 32'h0);
		check(rd, {26'h0, TAP_INIT});
		apb(1'b1, 8'h10, 32'hFF);
		check({31'h0, er}, 32'h1);
		apb(1'b0, REG_CTRL, 32'h0);
		check(rd, {22'h0, CTRL_RESET});
		$display("test reset done");
		repeat (2) dly(32'h3);
		check(rd & 32'h13F, 32'h2);
		repeat (3) dly(32'h1);
		check(rd & 32'h13F, 32'h0);
		repeat (64) dly(32'h3);
		check(rd & 32'h13F, 32'h3F);
		dly(32'h4);
		check(rd & 32'h13F, 32'h0);
		$display("test delay done");
		apb(1'b1, REG_CTRL, ctl(RX_PLAIN, TX_PLAIN, 1'b0, 1'b0, 1'b0));
		ext_p <= 1'b1;
		repeat (4) @(posedge clk_sys);
		apb(1'b0, REG_RXDATA, 32'h0);
		check(rd & 32'h31, 32'h11);
		ext_p <= 1'b0;
		ext_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		apb(1'b0, REG_RXDATA, 32'h0);
		check(rd & 32'h31, 32'h20);
		$display("test plain done");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, REG_CTRL, ctl(rm[i], TX_REG, 1'b0, 1'b0, 1'b0));
			rx_run(rpat[i]);
			check({28'h0, link.rx_word & rmask[i]}, {28'h0, rexp[i]});
		end
		$display("test capture done");
		// launch modes with the pad driven
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, REG_CTRL, ctl(RX_PLAIN, tm[i], 1'b1, i == 2, 1'b0));
			tx_run(tw[i], tseq[i]);
		end
		$display("test launch done");
		// differential pair, then two single pins
		apb(1'b1, REG_CTRL, ctl(RX_PLAIN, TX_PLAIN, 1'b1, 1'b0, 1'b1));
		repeat (4) @(posedge clk_sys);
		check({30'h0, n_oe, p_oe}, 32'h3);
		check({31'h0, n_o ^ p_o}, 32'h1);
		apb(1'b1, REG_CTRL, 32'h300);
		repeat (4) @(posedge clk_sys);
		check({29'h0, n_oe, n_o, p_oe}, 32'h6);
		$display("test pair done");
		// three words through the buffer, launched in write order, none lost
		apb(1'b1, REG_CTRL, ctl(RX_PLAIN, TX_REG, 1'b1, 1'b0, 1'b0));
		taken.delete();
		for (int i = 1; i < 4; i++) apb(1'b1, REG_TXDATA, 32'(i));
		repeat (16) @(posedge clk_sys);
		check(32'(taken.size()), 32'h3);
		for (int i = 0; i < 3; i++) check({28'h0, taken[i]}, 32'(i + 1));
		apb(1'b0, REG_TXDATA, 32'h0);
		check(rd & 32'h3, 32'h0);
		$display("test buffer done");
		finish_test();
	end
endmodule : hs_pin_pair_gpio_port_tb_top

// file: verilog/hpg_fabric_ctl.sv
`timescale 1ns/1ps
module hpg_fabric_ctl (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	hpg_link_if.fab LINK
);
	import hpg_pkg::*;

	logic [CTRL_W-1:0] ctrl_q;
	logic [WORD_W-1:0] buf_mem [0:1];
	logic wr_q;
	logic rd_q;
	logic [1:0] cnt_q;
	logic [WORD_W-1:0] rx_last_q;
	logic new_q;
	logic step_q;
	logic dir_q;
	logic clr_q;
	logic [31:0] rd_mux;

	// Address decode and APB phases; PREADY is registered so each access waits one cycle, a write to a full buffer longer
	wire hit_ctrl = (PADDR == REG_CTRL);
	wire hit_tx = (PADDR == REG_TXDATA);
	wire hit_rx = (PADDR == REG_RXDATA);
	wire hit_dly = (PADDR == REG_DELAY);
	wire hit_any = hit_ctrl | hit_tx | hit_rx | hit_dly;
	wire buf_full = (cnt_q == BUF_DEPTH);
	wire stall = PWRITE & hit_tx & buf_full;
	wire setup_acc = PSEL & PENABLE & ~PREADY;
	wire answer = setup_acc & ~stall;
	wire acc = PSEL & PENABLE & PREADY;
	wire wr_acc = acc & PWRITE & ~PSLVERR;
	wire rd_rx = acc & ~PWRITE & hit_rx;

	// Buffer handshake; a full buffer holds the write in its access phase
	wire push = wr_acc & hit_tx;
	wire pop = LINK.tx_valid & LINK.tx_ready;

	// Read data selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux[CTRL_W-1:0] = ctrl_q;
		end else if (hit_tx) begin
			rd_mux[TXS_CNT_LSB +: 2] = cnt_q;
		end else if (hit_rx) begin
			rd_mux[WORD_W-1:0] = rx_last_q;
			rd_mux[RXD_BYP_BIT] = LINK.bypass_pad_tap;
			rd_mux[RXD_AUX_BIT] = LINK.aux_in;
			rd_mux[RXD_NEW_BIT] = new_q;
		end else if (hit_dly) begin
			rd_mux[TAP_W-1:0] = LINK.delay_tap;
			rd_mux[DLY_BUSY_BIT] = step_q | clr_q;
		end
	end

	// APB answer registers
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= answer;
			PSLVERR <= answer & ~hit_any;
			PRDATA <= (answer & ~PWRITE) ? rd_mux : 32'h0000_0000;
		end
	end

	// Two-entry transmit buffer between software writes and the launch side
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
			buf_mem[0] <= 4'h0;
			buf_mem[1] <= 4'h0;
		end else begin
			if (push) begin
				buf_mem[wr_q] <= PWDATA[WORD_W-1:0];
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// Control register and delay requests; a new write wins over completion
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q <= CTRL_RESET;
			step_q <= 1'b0;
			dir_q <= 1'b0;
			clr_q <= 1'b0;
		end else begin
			if (wr_acc & hit_ctrl) begin
				ctrl_q <= PWDATA[CTRL_W-1:0];
			end
			if (wr_acc & hit_dly) begin
				step_q <= PWDATA[DLY_STEP_BIT];
				dir_q <= PWDATA[DLY_DIR_BIT];
				clr_q <= PWDATA[DLY_CLR_BIT];
			end else if (LINK.delay_step_done) begin
				step_q <= 1'b0;
				clr_q <= 1'b0;
			end
		end
	end

	// Received word; only a reported flag is cleared, a fresh word sets it again
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rx_last_q <= 4'h0;
			new_q <= 1'b0;
		end else begin
			if (LINK.rx_valid) begin
				rx_last_q <= LINK.rx_word;
			end
			new_q <= LINK.rx_valid | (new_q & ~(rd_rx & PRDATA[RXD_NEW_BIT]));
		end
	end

	// Configuration out to the pin pair
	assign LINK.cfg_diff = ctrl_q[CTRL_DIFF_BIT];
	assign LINK.cfg_rx_mode = hpg_rx_mode_e'(ctrl_q[CTRL_RX_LSB +: 3]);
	assign LINK.cfg_tx_mode = hpg_tx_mode_e'(ctrl_q[CTRL_TX_LSB +: 2]);
	assign LINK.cfg_oe_reg = ctrl_q[CTRL_OEREG_BIT];
	assign LINK.tx_word = buf_mem[rd_q];
	assign LINK.tx_valid = (cnt_q != 2'h0);
	assign LINK.tx_oe = ctrl_q[CTRL_DRIVE_BIT];
	// R7: same enable on both legs
	// R15: negative-leg controls unused in differential
	assign LINK.second_leg_drive_enable = ctrl_q[CTRL_DIFF_BIT] ? ctrl_q[CTRL_DRIVE_BIT]
		: ctrl_q[CTRL_AUXOE_BIT];
	assign LINK.aux_out = ctrl_q[CTRL_AUXO_BIT] & ~ctrl_q[CTRL_DIFF_BIT];
	// R8: enable held until step done
	assign LINK.delay_adjust_enable = step_q;
	assign LINK.delay_step_direction = dir_q;
	assign LINK.delay_counter_clear = clr_q;
endmodule : hpg_fabric_ctl

// file: verilog/hpg_link_if.sv
`timescale 1ns/1ps
interface hpg_link_if;
	// Static configuration from the fabric
	logic cfg_diff;
	hpg_pkg::hpg_rx_mode_e cfg_rx_mode;
	hpg_pkg::hpg_tx_mode_e cfg_tx_mode;
	logic cfg_oe_reg;
	// Launch path
	logic [hpg_pkg::WORD_W-1:0] tx_word;
	logic tx_valid;
	logic tx_ready;
	logic tx_oe;
	logic second_leg_drive_enable;
	logic aux_out;
	// Capture path
	logic [hpg_pkg::WORD_W-1:0] rx_word;
	logic rx_valid;
	logic bypass_pad_tap;
	logic aux_in;
	// Dynamic delay control
	logic delay_adjust_enable;
	logic delay_step_direction;
	logic delay_counter_clear;
	logic delay_step_done;
	logic [hpg_pkg::TAP_W-1:0] delay_tap;

	modport dev (
		input cfg_diff, cfg_rx_mode, cfg_tx_mode, cfg_oe_reg,
		input tx_word, tx_valid, tx_oe, second_leg_drive_enable, aux_out,
		input delay_adjust_enable, delay_step_direction, delay_counter_clear,
		output tx_ready, rx_word, rx_valid, bypass_pad_tap, aux_in,
		output delay_step_done, delay_tap
	);
	modport fab (
		output cfg_diff, cfg_rx_mode, cfg_tx_mode, cfg_oe_reg,
		output tx_word, tx_valid, tx_oe, second_leg_drive_enable, aux_out,
		output delay_adjust_enable, delay_step_direction, delay_counter_clear,
		input tx_ready, rx_word, rx_valid, bypass_pad_tap, aux_in,
		input delay_step_done, delay_tap
	);
endinterface : hpg_link_if

// file: verilog/hpg_pin_pair.sv
// Functional notes
// R1: Pair works as two pins or one differential
// R2: Plain on bit0; dual-edge rise bit0, fall bit1
// R3: Deserializer earliest bit0, latest bit3
// R4: Dual-edge launch bit0 rising, bit1 falling
// R5: Serializer sends bit0 first, bit3 last
// R6: Fabric enable drives pad, optionally registered
// R7: Fabric drives second leg enable same as primary
// R8: Enabled delay steps once: 1 up, 0 down
// R9: Clear returns delay counter to initial setting
// R10: Output register clock times data and enable
// R11: Fast shift clock drives the serializer
// R12: Input register clock times capture registers
// R13: Fast shift clock drives the deserializer
// R14: Unregistered pad offered on bypass output
// R15: Differential pair uses positive-leg core signals only
// R16: Resync delays falling sample half cycle
// R17: Resync hands both bits on rising edge
// R18: Delay input only, 64 steps of 25 ps
// R19: Delay counter saturates at both ends
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module hpg_pin_pair (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	hpg_link_if.dev LINK,
	input wire logic PAD_P_I,
	output logic PAD_P_O,
	output logic PAD_P_OE,
	input wire logic PAD_N_I,
	output logic PAD_N_O,
	output logic PAD_N_OE
);
	import hpg_pkg::*;

	logic [1:0] phase_q;
	logic [WORD_W-1:0] rx_sr_q;
	logic [WORD_W-1:0] rx_word_q;
	logic [WORD_W-1:0] rx_word_d;
	logic rx_valid_q;
	logic rx_valid_d;
	logic rx_fall_q;
	logic bypass_q;
	logic aux_in_q;
	logic [TAP_W-1:0] tap_q;
	logic [TAP_W-1:0] tap_d;
	logic done_q;
	logic done_d;
	logic [WORD_W-1:0] hold_q;
	logic [WORD_W-1:0] tx_sr_q;
	logic [WORD_W-1:0] tx_sr_d;
	logic pad_p_d;
	logic oe_p_q;
	logic oe_n_q;
	logic oe_n_src;

	// Divider: CLK_SYS is the fast shift clock, every fourth cycle a register edge
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			phase_q <= PH_RISE;
		end else begin
			phase_q <= phase_q + PH_ONE;
		end
	end

	// Register clock edges as enable pulses; a falling edge sits mid-period
	wire rise_en = (phase_q == PH_RISE);
	wire fall_en = (phase_q == PH_FALL);

	// The differential receiver resolves the pair onto the positive leg
	// R1: pair mode select
	wire rx_in = LINK.cfg_diff ? (PAD_P_I & ~PAD_N_I) : PAD_P_I;
	wire rx_plain = (LINK.cfg_rx_mode == RX_PLAIN);

	// Deserializer shifts on every fast cycle, newest bit enters at the top
	// R13: fast deserializer shift
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rx_sr_q <= 4'h0;
		end else begin
			rx_sr_q <= {rx_in, rx_sr_q[WORD_W-1:1]};
		end
	end

	// Falling-edge sample held until the next rising edge
	// R16: half cycle hold
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rx_fall_q <= 1'b0;
		end else if (fall_en) begin
			rx_fall_q <= rx_in;
		end
	end

	// Capture word selection per receive mode
	always_comb begin
		rx_word_d = rx_word_q;
		rx_valid_d = 1'b0;
		case (LINK.cfg_rx_mode)
			// R12: rising capture register
			RX_REG: begin
				if (rise_en) begin
					rx_word_d = {3'h0, rx_in};
					rx_valid_d = 1'b1;
				end
			end
			// R2: rise bit0 fall bit1
			RX_DDR: begin
				if (rise_en) begin
					rx_word_d = {rx_word_q[3:1], rx_in};
					rx_valid_d = 1'b1;
				end else if (fall_en) begin
					rx_word_d = {rx_word_q[3:2], rx_in, rx_word_q[0]};
					rx_valid_d = 1'b1;
				end
			end
			// R17: both on rising
			RX_DDR_RESYNC: begin
				if (rise_en) begin
					rx_word_d = {2'h0, rx_fall_q, rx_in};
					rx_valid_d = 1'b1;
				end
			end
			// R3: earliest in bit0
			RX_DESER: begin
				if (rise_en) begin
					rx_word_d = rx_sr_q;
					rx_valid_d = 1'b1;
				end
			end
			default: begin
				rx_word_d = {3'h0, rx_in};
				rx_valid_d = 1'b1;
			end
		endcase
	end

	// Capture outputs; the bypass tap only carries the pad with no register chosen
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rx_word_q <= 4'h0;
			rx_valid_q <= 1'b0;
			bypass_q <= 1'b0;
			aux_in_q <= 1'b0;
		end else begin
			rx_word_q <= rx_word_d;
			rx_valid_q <= rx_valid_d;
			// R14: bypass in plain mode
			bypass_q <= rx_plain & rx_in;
			aux_in_q <= PAD_N_I;
		end
	end

	// Delay counter updates once per register period; it never wraps
	always_comb begin
		tap_d = tap_q;
		done_d = 1'b0;
		if (rise_en) begin
			if (LINK.delay_counter_clear) begin
				// R9: back to initial
				tap_d = TAP_INIT;
				done_d = 1'b1;
			end else if (LINK.delay_adjust_enable) begin
				done_d = 1'b1;
				// R8: one step per update
				if (LINK.delay_step_direction) begin
					// R19: saturate at top
					if (tap_q != TAP_MAX) begin
						tap_d = tap_q + TAP_ONE;
					end
				end else begin
					// R19: saturate at bottom
					if (tap_q != TAP_MIN) begin
						tap_d = tap_q - TAP_ONE;
					end
				end
			end
		end
	end

	// The tap drives the analog input chain of the positive leg, never the output
	// R18: input-only 64 taps
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			tap_q <= TAP_INIT;
			done_q <= 1'b0;
		end else begin
			tap_q <= tap_d;
			done_q <= done_d;
		end
	end

	assign LINK.rx_word = rx_word_q;
	assign LINK.rx_valid = rx_valid_q;
	assign LINK.bypass_pad_tap = bypass_q;
	assign LINK.aux_in = aux_in_q;
	assign LINK.delay_tap = tap_q;
	assign LINK.delay_step_done = done_q;

	// Launch side takes a word per rising register edge, or every cycle when plain
	wire tx_plain = (LINK.cfg_tx_mode == TX_PLAIN);
	wire take_en = tx_plain | rise_en;
	wire take = take_en & LINK.tx_valid;
	// An empty buffer repeats the last word rather than sending garbage
	wire [WORD_W-1:0] word_now = take ? LINK.tx_word : hold_q;
	assign LINK.tx_ready = take_en;

	// Serializer loads on the register edge and shifts every fast cycle
	// R11: fast serializer shift
	assign tx_sr_d = rise_en ? {1'b0, word_now[3:1]} : {1'b0, tx_sr_q[3:1]};

	// Pad data per launch mode
	always_comb begin
		pad_p_d = PAD_P_O;
		case (LINK.cfg_tx_mode)
			// R10: rising output register
			TX_REG: begin
				if (rise_en) begin
					pad_p_d = word_now[0];
				end
			end
			// R4: rise bit0 fall bit1
			TX_DDR: begin
				if (rise_en) begin
					pad_p_d = word_now[0];
				end else if (fall_en) begin
					pad_p_d = hold_q[1];
				end
			end
			// R5: bit0 first
			TX_SER: begin
				pad_p_d = rise_en ? word_now[0] : tx_sr_q[0];
			end
			default: begin
				pad_p_d = word_now[0];
			end
		endcase
	end

	// Enables follow the fabric each cycle, or only at the register edge
	// R6: optional enable register
	wire oe_upd = ~LINK.cfg_oe_reg | rise_en;
	// R7: second leg enable
	assign oe_n_src = LINK.second_leg_drive_enable;

	// Launch registers; the negative leg mirrors in differential mode
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			hold_q <= 4'h0;
			tx_sr_q <= 4'h0;
			PAD_P_O <= 1'b0;
			PAD_N_O <= 1'b0;
			oe_p_q <= 1'b0;
			oe_n_q <= 1'b0;
		end else begin
			hold_q <= word_now;
			tx_sr_q <= tx_sr_d;
			PAD_P_O <= pad_p_d;
			// R1: complement or independent pin
			PAD_N_O <= LINK.cfg_diff ? ~pad_p_d : LINK.aux_out;
			if (oe_upd) begin
				oe_p_q <= LINK.tx_oe;
				oe_n_q <= oe_n_src;
			end
		end
	end

	assign PAD_P_OE = oe_p_q;
	assign PAD_N_OE = oe_n_q;
endmodule : hpg_pin_pair

// file: verilog/hpg_pkg.sv
package hpg_pkg;
	// Parallel word and delay tap widths
	localparam int WORD_W = 4;
	localparam int TAP_W = 6;
	localparam int TAP_COUNT = 64;
	localparam int TAP_STEP_PS = 25;
	localparam logic [5:0] TAP_INIT = 6'h00;
	localparam logic [5:0] TAP_MIN = 6'h00;
	localparam logic [5:0] TAP_MAX = 6'h3F;
	localparam logic [5:0] TAP_ONE = 6'h01;

	// Register clock phases within the four-cycle divider period
	localparam logic [1:0] PH_RISE = 2'h0;
	localparam logic [1:0] PH_FALL = 2'h2;
	localparam logic [1:0] PH_ONE = 2'h1;

	// Capture and launch modes
	typedef enum logic [2:0] {
		RX_PLAIN,
		RX_REG,
		RX_DDR,
		RX_DDR_RESYNC,
		RX_DESER
	} hpg_rx_mode_e;
	typedef enum logic [1:0] {
		TX_PLAIN,
		TX_REG,
		TX_DDR,
		TX_SER
	} hpg_tx_mode_e;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TXDATA = 8'h04;
	localparam logic [7:0] REG_RXDATA = 8'h08;
	localparam logic [7:0] REG_DELAY = 8'h0C;

	// Control register fields
	localparam int CTRL_W = 10;
	localparam logic [9:0] CTRL_RESET = 10'h000;
	localparam int CTRL_DIFF_BIT = 0;
	localparam int CTRL_RX_LSB = 1;
	localparam int CTRL_TX_LSB = 4;
	localparam int CTRL_OEREG_BIT = 6;
	localparam int CTRL_DRIVE_BIT = 7;
	localparam int CTRL_AUXO_BIT = 8;
	localparam int CTRL_AUXOE_BIT = 9;

	// Receive and delay register fields
	localparam int RXD_BYP_BIT = 4;
	localparam int RXD_AUX_BIT = 5;
	localparam int RXD_NEW_BIT = 6;
	localparam int DLY_STEP_BIT = 0;
	localparam int DLY_DIR_BIT = 1;
	localparam int DLY_CLR_BIT = 2;
	localparam int DLY_BUSY_BIT = 8;
	localparam int TXS_CNT_LSB = 0;

	// Transmit buffer depth
	localparam logic [1:0] BUF_DEPTH = 2'h2;
endpackage : hpg_pkg
